// >>> hdl/codec_serial_defs.vh
// Constants for the codec serial port: reset values, control bits, timing
`ifndef CODEC_SERIAL_DEFS_VH
`define CODEC_SERIAL_DEFS_VH
// Master clock and conversion rate
`define MAIN_CLOCK_KHZ      5184
`define CONV_RATE_KHZ       8
`define FILTER_CLOCK_KHZ    288
// Reset divider values: 5184/(2*9) = 288 kHz, 288/36 = 8 kHz
`define DIV_A_RESET         8'h09
`define DIV_B_RESET         8'h24
`define STEP_ADJ_RESET      8'h01
// Control register reset value: d7..d2 = 1,1,1,0,0,1 (d1 loopback, d0 unused)
`define CTRL_RESET          8'hE4
// Control bit positions
`define CTRL_SYNC_BIT       5
`define CTRL_AUX_BIT        4
`define CTRL_LOOP_BIT       1
// Shift clock divide ratio and sync pulse width
`define SHIFT_DIV           4
`define SYNC_PULSE_SHIFTS   4
`define WORD_BITS           16
`define BYTE_BITS           8
`endif

// >>> hdl/shift_clock_gen.v
// Shift clock divider: master clock divided by four, with edge strobes
module shift_clock_gen #(
   parameter DIV = 4
) (
   input  wire clock_i,
   input  wire rst_b_i,
   output reg  shift_clk_o,
   output reg  rise_o,
   output reg  fall_o
);
   reg [7:0] count;
   // Divider counter; restarts on reset
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         count       <= 8'h00;
         shift_clk_o <= 1'b0;
         rise_o      <= 1'b0;
         fall_o      <= 1'b0;
      end else begin
         count       <= (count == DIV - 1) ? 8'h00 : count + 8'h01;
         shift_clk_o <= (count < DIV / 2);
         rise_o      <= (count == 8'h00);
         fall_o      <= (count == DIV / 2);
      end
   end
endmodule

// >>> hdl/word_fifo.v
// Small FIFO with valid and ready on both sides
module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clock_i,
   input  wire             rst_b_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      fill;
   wire            push;
   wire            pop;
   assign in_ready_o  = (fill != DEPTH);
   assign out_valid_o = (fill != 0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   // Storage write
   always @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   // Pointers and fill level
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill   <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            fill <= fill + 1'b1;
         end else if (pop && !push) begin
            fill <= fill - 1'b1;
         end
      end
   end
endmodule

// >>> hdl/codec_serial_port.v
// Codec serial port, divider registers, control register and reset logic
// Summary of operation
// - Reset pulse initialises all internal registers; result buffer storage is not reset
// - Reset dividers give 8 kHz at 5.184 MHz
// - Reset loads step adjust registers with one
// - Reset sets d7,d6,d5,d2, clears d4,d3
// - Loopback routes output to primary input
// - Sample data sits in bits d15..d2
// - Control bit selects auxiliary over primary input
// - Results shift out on shift clock
// - Word mode: receive done pulses after 16 bits
// - Byte mode: receive done low between bytes
// - Word mode: transmit done pulses after 16 bits
// - Byte mode: transmit done low between bytes
// - Receive sync low during transfer, MSB first
// - Transmit sync low during incoming transfer
// - Shift clock is master clock divided four
// - All timing derived from master clock
// - Control bit and width pin pick mode
// - Byte mode: sync low, byte, done low
// - Byte mode: four-clock sync pulse, second byte
// - Word mode: sync low, word, high, done pulse
// - Synchronous mode: no receive sync on secondary
`include "codec_serial_defs.vh"
module codec_serial_port #(
   parameter DIV_A_INIT = `DIV_A_RESET,
   parameter DIV_B_INIT = `DIV_B_RESET
) (
   input  wire        clock_i,
   input  wire        rst_b_i,
   input  wire        width_select_pin_i,
   input  wire        serial_in_line_i,
   input  wire        adc_valid_i,
   input  wire [13:0] adc_sample_i,
   output wire        adc_ready_o,
   input  wire        secondary_i,
   output reg         shift_clock_o,
   output reg         serial_out_line_o,
   output reg         xmit_sync_out_o,
   output reg         rcv_sync_out_o,
   output reg         xmit_done_flag_o,
   output reg         rcv_done_flag_o,
   output reg  [13:0] dac_sample_o,
   output reg         dac_strobe_o,
   output reg  [7:0]  control_o,
   output reg  [7:0]  tx_divider_a_value_o,
   output reg  [7:0]  tx_divider_b_value_o,
   output reg  [7:0]  tx_step_adjust_o,
   output reg  [7:0]  rx_divider_a_value_o,
   output reg  [7:0]  rx_divider_b_value_o,
   output reg  [7:0]  rx_step_adjust_o,
   output reg         loopback_o,
   output reg         aux_select_o,
   output reg         tx_conv_strobe_o,
   output reg         rx_conv_strobe_o
);
   // ---------------------------------------------------------------
   // Frame states
   // ---------------------------------------------------------------
   localparam ST_IDLE  = 3'h0;
   localparam ST_BYTE1 = 3'h1;
   localparam ST_PULSE = 3'h2;
   localparam ST_BYTE2 = 3'h3;
   localparam ST_WORD  = 3'h4;
   localparam ST_DONE  = 3'h5;
   localparam ST_END   = 3'h6;

   wire        sclk;
   wire        srise;
   wire        sfall;
   wire        fifo_valid;
   wire [13:0] fifo_data;
   reg         fifo_pop;
   reg  [2:0]  state;
   reg  [4:0]  bit_cnt;
   reg  [15:0] out_shift;
   reg  [15:0] in_shift;
   reg         rx_active;
   reg  [7:0]  tx_a_cnt;
   reg  [7:0]  tx_b_cnt;
   reg  [7:0]  rx_a_cnt;
   reg  [7:0]  rx_b_cnt;
   reg         frame_req;
   wire        sync_mode;
   wire        byte_mode;

   assign sync_mode = control_o[`CTRL_SYNC_BIT];
   assign byte_mode = !width_select_pin_i;

   // ---------------------------------------------------------------
   // Shift clock and result buffer
   // ---------------------------------------------------------------
   shift_clock_gen #(
      .DIV (`SHIFT_DIV)
   ) u_sclk (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .shift_clk_o (sclk),
      .rise_o      (srise),
      .fall_o      (sfall)
   );

   word_fifo #(
      .WIDTH (14),
      .DEPTH (4),
      .AW    (2)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (adc_valid_i),
      .in_ready_o  (adc_ready_o),
      .in_data_i   (adc_sample_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   // ---------------------------------------------------------------
   // Conversion timing dividers
   // ---------------------------------------------------------------
   // Counter A then B per section; transmit timing drives both in sync mode
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         tx_a_cnt         <= 8'h00;
         tx_b_cnt         <= 8'h00;
         rx_a_cnt         <= 8'h00;
         rx_b_cnt         <= 8'h00;
         tx_conv_strobe_o <= 1'b0;
         rx_conv_strobe_o <= 1'b0;
         frame_req        <= 1'b0;
      end else begin
         tx_conv_strobe_o <= 1'b0;
         rx_conv_strobe_o <= 1'b0;
         // Request taken by the idle engine; a strobe in the same cycle wins
         if (srise && state == ST_IDLE) begin
            frame_req <= 1'b0;
         end
         // Counter A counts 2*A master clocks per filter clock
         if (tx_a_cnt == {tx_divider_a_value_o[6:0], 1'b0} - 8'h01) begin
            tx_a_cnt <= 8'h00;
            if (tx_b_cnt == tx_divider_b_value_o - 8'h01) begin
               tx_b_cnt         <= 8'h00;
               tx_conv_strobe_o <= 1'b1;
               frame_req        <= 1'b1;
               if (sync_mode) begin
                  rx_conv_strobe_o <= 1'b1;
               end
            end else begin
               tx_b_cnt <= tx_b_cnt + 8'h01;
            end
         end else begin
            tx_a_cnt <= tx_a_cnt + 8'h01;
         end
         if (rx_a_cnt == {rx_divider_a_value_o[6:0], 1'b0} - 8'h01) begin
            rx_a_cnt <= 8'h00;
            if (rx_b_cnt == rx_divider_b_value_o - 8'h01) begin
               rx_b_cnt <= 8'h00;
               if (!sync_mode) begin
                  rx_conv_strobe_o <= 1'b1;
               end
            end else begin
               rx_b_cnt <= rx_b_cnt + 8'h01;
            end
         end else begin
            rx_a_cnt <= rx_a_cnt + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial frame engine
   // ---------------------------------------------------------------
   // Outputs change on shift clock rising strobe, input sampled on falling
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         state             <= ST_IDLE;
         bit_cnt           <= 5'h00;
         out_shift         <= 16'h0000;
         in_shift          <= 16'h0000;
         rx_active         <= 1'b0;
         serial_out_line_o <= 1'b0;
         xmit_sync_out_o   <= 1'b1;
         rcv_sync_out_o    <= 1'b1;
         xmit_done_flag_o  <= 1'b1;
         rcv_done_flag_o   <= 1'b1;
         dac_sample_o      <= 14'h0000;
         dac_strobe_o      <= 1'b0;
         fifo_pop          <= 1'b0;
         shift_clock_o     <= 1'b0;
      end else begin
         shift_clock_o <= sclk;
         dac_strobe_o  <= 1'b0;
         fifo_pop      <= 1'b0;
         // Far port shifts only while transmit sync is low
         if (sfall && !xmit_sync_out_o) begin
            in_shift <= {in_shift[14:0], serial_in_line_i};
         end
         if (srise) begin
            case (state)
               ST_IDLE: begin
                  if (frame_req) begin
                     // Result buffer supplies the word; secondary frames in sync mode carry none
                     rx_active <= fifo_valid && !(sync_mode && secondary_i);
                     fifo_pop  <= fifo_valid && !(sync_mode && secondary_i);
                     out_shift <= {fifo_data, 2'b00};
                     serial_out_line_o <= fifo_data[13];
                     bit_cnt   <= 5'h00;
                     state     <= byte_mode ? ST_BYTE1 : ST_WORD;
                  end
               end
               ST_WORD, ST_BYTE1, ST_BYTE2: begin
                  xmit_sync_out_o <= 1'b0;
                  rcv_sync_out_o  <= !rx_active;
                  if (bit_cnt != 5'h00) begin
                     serial_out_line_o <= out_shift[15];
                  end
                  out_shift <= {out_shift[14:0], 1'b0};
                  bit_cnt   <= bit_cnt + 5'h01;
                  if (state == ST_WORD && bit_cnt == `WORD_BITS - 1) begin
                     state   <= ST_DONE;
                     bit_cnt <= 5'h00;
                  end else if (state == ST_BYTE1 && bit_cnt == `BYTE_BITS - 1) begin
                     state   <= ST_PULSE;
                     bit_cnt <= 5'h00;
                  end else if (state == ST_BYTE2 && bit_cnt == `BYTE_BITS - 1) begin
                     state   <= ST_END;
                     bit_cnt <= 5'h00;
                  end
               end
               ST_PULSE: begin
                  // Done low, sync high for four shift clocks
                  xmit_done_flag_o <= 1'b0;
                  rcv_done_flag_o  <= !rx_active;
                  xmit_sync_out_o  <= 1'b1;
                  rcv_sync_out_o   <= 1'b1;
                  bit_cnt          <= bit_cnt + 5'h01;
                  if (bit_cnt == `SYNC_PULSE_SHIFTS - 1) begin
                     state   <= ST_BYTE2;
                     bit_cnt <= 5'h00;
                     serial_out_line_o <= out_shift[15];
                  end
               end
               ST_DONE: begin
                  // Sync returns high, then done pulses for one shift clock
                  xmit_sync_out_o <= 1'b1;
                  rcv_sync_out_o  <= 1'b1;
                  bit_cnt         <= bit_cnt + 5'h01;
                  if (bit_cnt == 5'h01) begin
                     xmit_done_flag_o <= 1'b0;
                     rcv_done_flag_o  <= !rx_active;
                  end else if (bit_cnt == 5'h02) begin
                     xmit_done_flag_o <= 1'b1;
                     rcv_done_flag_o  <= 1'b1;
                     state            <= ST_END;
                  end
               end
               ST_END: begin
                  // Byte mode: done and sync return high together
                  xmit_done_flag_o <= 1'b1;
                  rcv_done_flag_o  <= 1'b1;
                  xmit_sync_out_o  <= 1'b1;
                  rcv_sync_out_o   <= 1'b1;
                  dac_sample_o     <= in_shift[15:2];
                  dac_strobe_o     <= 1'b1;
                  state            <= ST_IDLE;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers, reset defaults and control decode
   // ---------------------------------------------------------------
   // Control word: d1..d0 of a received word pick register writes
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         control_o            <= `CTRL_RESET;
         tx_divider_a_value_o <= DIV_A_INIT;
         tx_divider_b_value_o <= DIV_B_INIT;
         rx_divider_a_value_o <= DIV_A_INIT;
         rx_divider_b_value_o <= DIV_B_INIT;
         tx_step_adjust_o     <= `STEP_ADJ_RESET;
         rx_step_adjust_o     <= `STEP_ADJ_RESET;
         loopback_o           <= 1'b0;
         aux_select_o         <= 1'b0;
      end else begin
         loopback_o   <= control_o[`CTRL_LOOP_BIT];
         aux_select_o <= control_o[`CTRL_AUX_BIT];
         if (dac_strobe_o && secondary_i) begin
            case (in_shift[1:0])
               2'b00: begin
                  tx_divider_a_value_o <= in_shift[15:8];
                  rx_divider_a_value_o <= in_shift[7:0];
               end
               2'b01: begin
                  tx_step_adjust_o <= in_shift[15:8];
                  rx_step_adjust_o <= in_shift[7:0];
               end
               2'b10: begin
                  tx_divider_b_value_o <= in_shift[15:8];
                  rx_divider_b_value_o <= in_shift[7:0];
               end
               default: begin
                  control_o <= in_shift[7:0];
               end
            endcase
         end
      end
   end
endmodule

// >>> verification/codec_serial_port_sva.sv
// Concurrent checks on the codec serial port pins
`include "codec_serial_defs.vh"
module codec_serial_port_sva (
   input wire logic       clock_i,
   input wire logic       rst_b_i,
   input wire logic       width_select_pin_i,
   input wire logic       secondary_i,
   input wire logic       adc_valid_i,
   input wire logic       adc_ready_o,
   input wire logic       shift_clock_o,
   input wire logic       xmit_sync_out_o,
   input wire logic       rcv_sync_out_o,
   input wire logic       xmit_done_flag_o,
   input wire logic       rcv_done_flag_o,
   input wire logic [7:0] control_o,
   input wire logic [7:0] tx_divider_a_value_o,
   input wire logic [7:0] tx_divider_b_value_o,
   input wire logic [7:0] tx_step_adjust_o,
   input wire logic [7:0] rx_divider_a_value_o,
   input wire logic [7:0] rx_divider_b_value_o,
   input wire logic [7:0] rx_step_adjust_o,
   input wire logic       loopback_o,
   input wire logic       aux_select_o,
   input wire logic       tx_conv_strobe_o,
   input wire logic       rx_conv_strobe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  lo_x = 8'h00;
   logic [7:0]  lo_r = 8'h00;
   logic [7:0]  hi_x = 8'h00;
   logic [15:0] gap  = 16'h0000;
   logic        seen = 1'b0;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   // Run lengths of sync levels, gap between conversion strobes
   always @(posedge clock_i) begin
      lo_x <= xmit_sync_out_o ? 8'h00 : lo_x + 8'h01;
      lo_r <= rcv_sync_out_o ? 8'h00 : lo_r + 8'h01;
      hi_x <= xmit_sync_out_o ? hi_x + 8'h01 : 8'h00;
      gap  <= tx_conv_strobe_o ? 16'h0000 : gap + 16'h0001;
      seen <= rst_b_i & (seen | tx_conv_strobe_o);
   end
   AST_SHIFT_HIGH: assert property ($rose(shift_clock_o) |=> shift_clock_o ##1 !shift_clock_o)
      else $error("shift clock high phase wrong");
   AST_SHIFT_LOW: assert property ($fell(shift_clock_o) |=> !shift_clock_o ##1 shift_clock_o)
      else $error("shift clock low phase wrong");
   AST_RESET_CTRL: assert property ($rose(rst_b_i) |-> control_o == `CTRL_RESET)
      else $error("control not at reset value");
   AST_RESET_DIV: assert property ($rose(rst_b_i) |-> tx_divider_a_value_o == `DIV_A_RESET
      && tx_divider_b_value_o == `DIV_B_RESET && rx_divider_a_value_o == `DIV_A_RESET
      && rx_divider_b_value_o == `DIV_B_RESET) else $error("dividers not at reset value");
   AST_RESET_STEP: assert property ($rose(rst_b_i) |-> tx_step_adjust_o == `STEP_ADJ_RESET
      && rx_step_adjust_o == `STEP_ADJ_RESET) else $error("step adjust not one");
   AST_XMIT_LEN: assert property ($rose(xmit_sync_out_o)
      |-> lo_x == (width_select_pin_i ? 8'h40 : 8'h20)) else $error("transmit sync length");
   AST_RCV_LEN: assert property ($rose(rcv_sync_out_o)
      |-> lo_r == (width_select_pin_i ? 8'h40 : 8'h20)) else $error("receive sync length");
   AST_BYTE_GAP: assert property (!width_select_pin_i && $fell(xmit_sync_out_o)
      && !xmit_done_flag_o |-> hi_x == 8'h10) else $error("byte sync pulse width");
   AST_XMIT_DONE: assert property (width_select_pin_i && $fell(xmit_done_flag_o)
      |-> (xmit_sync_out_o && !xmit_done_flag_o) ##1 !xmit_done_flag_o[*3] ##1 xmit_done_flag_o)
      else $error("transmit done pulse");
   AST_RCV_DONE: assert property (width_select_pin_i && $fell(rcv_done_flag_o)
      |-> (rcv_sync_out_o && !rcv_done_flag_o) ##1 !rcv_done_flag_o[*3] ##1 rcv_done_flag_o)
      else $error("receive done pulse");
   AST_SECONDARY: assert property (control_o[`CTRL_SYNC_BIT] && secondary_i
      && $fell(xmit_sync_out_o) |-> rcv_sync_out_o) else $error("receive sync on secondary");
   AST_MODE_BITS: assert property ($stable(control_o) |->
      loopback_o == control_o[`CTRL_LOOP_BIT] && aux_select_o == control_o[`CTRL_AUX_BIT])
      else $error("mode levels differ from control");
   AST_CONV_PERIOD: assert property (tx_conv_strobe_o && seen |-> gap + 16'h0001
      == 16'h0002 * tx_divider_a_value_o * tx_divider_b_value_o) else $error("conversion period");
   AST_SYNC_STROBE: assert property (control_o[`CTRL_SYNC_BIT] && $stable(control_o)
      |-> rx_conv_strobe_o == tx_conv_strobe_o) else $error("receive strobe off transmit");
   COV_WORD: cover property (width_select_pin_i && $rose(rcv_done_flag_o));
   COV_BYTE: cover property (!width_select_pin_i && $rose(rcv_done_flag_o));
   COV_FULL: cover property (adc_valid_i && !adc_ready_o);
endmodule
bind codec_serial_port codec_serial_port_sva u_sva (.*);

// >>> verification/dsp_port_model.sv
// Behavioural model of the far serial port
module dsp_port_model (
   input  wire logic  shift_clock_i,
   input  wire logic  xmit_sync_i,
   input  wire logic  rcv_sync_i,
   input  wire logic  xmit_done_i,
   input  wire logic  rcv_done_i,
   input  wire logic  data_i,
   input  wire logic  secondary_i,
   output logic       data_o = 1'b0,
   output logic [15:0] frame_word_o = 16'h0000,
   output logic [15:0] rx_word_o = 16'h0000,
   output logic [7:0] rx_count_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] seed  = 16'hACE1;
   logic [15:0] shreg = 16'h0000;
   int          tx_n  = 0;
   int          rx_n  = 0;
   // New word at frame start, MSB first, d1..d0 mark secondary
   always @(negedge xmit_sync_i) if (tx_n == 0) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      frame_word_o = {seed[15:2], secondary_i, secondary_i};
      data_o = frame_word_o[15];
   end
   // Next bit after each taken bit, junk once the word is out
   always @(posedge shift_clock_i) if (!xmit_sync_i) begin
      data_o = (tx_n < 16) ? frame_word_o[15 - tx_n] : ~data_o;
   end
   // Count bits taken, collect result bits
   always @(negedge shift_clock_i) begin
      if (!xmit_sync_i) tx_n++;
      if (!rcv_sync_i) begin
         shreg = {shreg[14:0], data_i};
         rx_n++;
      end
   end
   // Frame end: line released shows the inverse level
   always @(posedge xmit_done_i) begin
      tx_n = 0;
      data_o = ~data_o;
   end
   // Hand over a collected result
   always @(posedge rcv_done_i) if (rx_n != 0) begin
      rx_word_o = shreg;
      rx_count_o++;
      rx_n = 0;
   end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the codec serial port
`include "codec_serial_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        width_select_pin_i = 1'b1;
   logic        adc_valid_i = 1'b0;
   logic        secondary_i = 1'b0;
   logic [13:0] adc_sample_i = 14'h0000;
   wire         serial_in_line_i, adc_ready_o, shift_clock_o, serial_out_line_o;
   wire         xmit_sync_out_o, rcv_sync_out_o, xmit_done_flag_o, rcv_done_flag_o;
   wire         dac_strobe_o, loopback_o, aux_select_o, tx_conv_strobe_o, rx_conv_strobe_o;
   wire [13:0]  dac_sample_o;
   wire [7:0]   control_o, tx_divider_a_value_o, tx_divider_b_value_o, tx_step_adjust_o;
   wire [7:0]   rx_divider_a_value_o, rx_divider_b_value_o, rx_step_adjust_o, rx_count;
   wire [15:0]  frame_word, rx_word;
   logic [31:0] rng = 32'hEB64CB2A;
   logic [13:0] exp_q[$];
   int          miscompares = 0;
   int          comparisons = 0;
   int          cycles = 0;
   codec_serial_port dut (.*);
   dsp_port_model pm (.shift_clock_i(shift_clock_o), .xmit_sync_i(xmit_sync_out_o),
      .rcv_sync_i(rcv_sync_out_o), .xmit_done_i(xmit_done_flag_o), .rcv_done_i(rcv_done_flag_o),
      .data_i(serial_out_line_o), .secondary_i(secondary_i), .data_o(serial_in_line_i),
      .frame_word_o(frame_word), .rx_word_o(rx_word), .rx_count_o(rx_count));
   always #5 clock_i = ~clock_i;
   function automatic logic [13:0] xorshift();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[13:0];
   endfunction
   function automatic logic [31:0] rate_khz(input logic [7:0] a, input logic [7:0] b);
      return `MAIN_CLOCK_KHZ / (2 * a * b);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      comparisons++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, want);
      end
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Offer one result, hold it until taken
   task automatic push(input logic [13:0] s, output int waits);
      waits = 0;
      adc_sample_i = s;
      adc_valid_i = 1'b1;
      @(posedge clock_i);
      while (adc_ready_o !== 1'b1) begin
         waits++;
         @(posedge clock_i);
      end
      #1 adc_valid_i = 1'b0;
      @(posedge clock_i);
      #1;
   endtask
   task automatic check_reset();
      check(control_o, `CTRL_RESET, "control");
      check(rate_khz(tx_divider_a_value_o, tx_divider_b_value_o), `CONV_RATE_KHZ, "tx rate");
      check(rate_khz(rx_divider_a_value_o, rx_divider_b_value_o), `CONV_RATE_KHZ, "rx rate");
      check({tx_step_adjust_o, rx_step_adjust_o}, {`STEP_ADJ_RESET, `STEP_ADJ_RESET}, "step");
      check({loopback_o, aux_select_o, xmit_sync_out_o, rcv_sync_out_o, xmit_done_flag_o,
             rcv_done_flag_o}, 6'h0F, "idle pins");
   endtask
   // Watchdog against a hung run
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // Record results the buffer took
   always @(posedge clock_i) if (rst_b_i && adc_valid_i && adc_ready_o) exp_q.push_back(adc_sample_i);
   // Decoded word against what the far port sent
   always @(posedge clock_i) if (dac_strobe_o === 1'b1 && frame_word[1:0] == 2'h0) begin
      check(dac_sample_o, frame_word[15:2], "dac word");
   end
   // Each collected result against the oldest offered
   always @(rx_count) if (rx_count != 8'h00) begin
      check(exp_q.size() > 0, 1, "extra result");
      if (exp_q.size() > 0) check(rx_word[15:2], exp_q.pop_front(), "result word");
   end
   // Main sequence
   initial begin
      int w;
      repeat (12) @(posedge clock_i);
      #1 rst_b_i = 1'b1;
      check_reset();
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         push(i == 0 ? 14'h3FFF : i == 1 ? 14'h0000 : xorshift(), w);
         check(w > 0, i == 4, "buffer refusal");
      end
      wait (rx_count == 8'h05);
      $display("test word mode done");
      // Frame kind changes only once the last word has been decoded
      @(posedge dac_strobe_o);
      @(posedge clock_i);
      #1 secondary_i = 1'b1;
      push(xorshift(), w);
      @(posedge dac_strobe_o);
      repeat (2) @(posedge clock_i);
      #1 secondary_i = 1'b0;
      check(rx_count, 8'h05, "secondary frame");
      check(control_o, frame_word[7:0], "control write");
      check({loopback_o, aux_select_o}, {frame_word[1], frame_word[4]}, "mode bits");
      wait (rx_count == 8'h06);
      $display("test secondary done");
      @(posedge xmit_done_flag_o);
      #1 width_select_pin_i = 1'b0;
      repeat (3) push(xorshift(), w);
      wait (rx_count == 8'h09);
      $display("test byte mode done");
      @(posedge xmit_done_flag_o);
      wait (xmit_sync_out_o && rcv_sync_out_o);
      @(posedge clock_i);
      #1 rst_b_i = 1'b0;
      width_select_pin_i = 1'b1;
      repeat (3) @(posedge clock_i);
      #1 rst_b_i = 1'b1;
      check_reset();
      push(xorshift(), w);
      wait (rx_count == 8'h0A);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
